// ---- mcuf_pkg.sv ----
// Package for the modem control register upper fields: field layout, reset values
// and the decoded configuration carrier.
// Assumes a single 20 MHz clock domain and a parallel write port fed by the serial front end.
package mcuf_pkg;

   // Control register geometry.
   localparam int CTRL_W      = 48;
   localparam int SHORT_W     = 24;

   // Field positions.
   localparam int DET_LO      = 12;
   localparam int DET_HI      = 13;
   localparam int MAINS_BIT   = 14;
   localparam int CLK_LO      = 15;
   localparam int CLK_HI      = 16;
   localparam int FREEZE_BIT  = 17;
   localparam int HDRREC_BIT  = 18;
   localparam int FLCNT_BIT   = 19;
   localparam int HDRLEN_BIT  = 20;
   localparam int EXT_BIT     = 21;
   localparam int SENS_BIT    = 22;
   localparam int FILT_BIT    = 23;
   localparam int HDR_LO      = 24;
   localparam int HDR_HI      = 39;
   localparam int LEN_LO      = 40;
   localparam int LEN_HI      = 47;

   // Detection method codes.
   localparam logic [1:0] DET_CARR_FREE  = 2'h0;
   localparam logic [1:0] DET_CARR_COND  = 2'h1;
   localparam logic [1:0] DET_PRE_FREE   = 2'h2;
   localparam logic [1:0] DET_PRE_COND   = 2'h3;

   // Output clock codes.
   localparam logic [1:0] CLK_DIV1 = 2'h0;
   localparam logic [1:0] CLK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_DIV4 = 2'h2;
   localparam logic [1:0] CLK_OFF  = 2'h3;

   // Values after reset.
   localparam logic [1:0]  DET_RST    = DET_PRE_FREE;
   localparam logic        MAINS_RST  = 1'b1;
   localparam logic [1:0]  CLK_RST    = CLK_DIV4;
   localparam logic        FREEZE_RST = 1'b1;
   localparam logic        HDRREC_RST = 1'b0;
   localparam logic        FLCNT_RST  = 1'b0;
   localparam logic        HDRLEN_RST = 1'b1;
   localparam logic        EXT_RST    = 1'b0;
   localparam logic        SENS_RST   = 1'b0;
   localparam logic        FILT_RST   = 1'b0;
   localparam logic [15:0] HDR_RST    = 16'h9b58;
   localparam logic [7:0]  LEN_RST    = 8'h08;
   localparam logic [7:0]  LEN_ZERO   = 8'h00;

   // Divider counter width and the UART idle level on receive data.
   localparam int         DIVCNT_W   = 2;
   localparam logic       UART_IDLE  = 1'b1;

   // Decoded feature enables and field values handed to the datapath.
   typedef struct packed {
      logic        freeze_en;
      logic        hdr_rec_en;
      logic        frame_cnt_en;
      logic        hdr_16bit;
      logic        mains_async;
      logic        high_sens;
      logic        in_filter;
      logic [15:0] frame_header;
      logic [7:0]  frame_len;
   } mcuf_cfg_t;

   // Raw receive path from the demodulator.
   typedef struct packed {
      logic carrier;
      logic preamble;
      logic pll_locked;
      logic bit_clock;
      logic data;
   } mcuf_rx_t;

endpackage : mcuf_pkg

// ---- mcuf_clkdiv.sv ----
// Master clock output divider for the modem control block.
// Assumes the selection comes from the control register in the same clock domain.
`timescale 1ns/1ns
module mcuf_clkdiv
   import mcuf_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Selection
   input  wire logic [1:0] sel_i,
   // Divided clock
   output logic            mclk_o
);

   logic [1:0]          sel_r;
   logic [DIVCNT_W-1:0] cnt_r;
   logic                mclk_r;
   logic                wrap;

   // The output is a square wave with period 2, 4 or 8 system clocks; only the ratio between
   // settings is kept, since a flip-flop cannot emit the undivided reference itself.
   always_comb begin
      unique case (sel_r)
         CLK_DIV1: wrap = 1'b1;
         CLK_DIV2: wrap = cnt_r[0];
         CLK_DIV4: wrap = &cnt_r;
         CLK_OFF:  wrap = 1'b1;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else if (wrap) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + DIVCNT_W'(1);
      end
   end

   // A new ratio is taken only at the end of a whole output period, so no runt pulse appears between ratios; a change to off leaves a one-cycle high pulse.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_r <= CLK_RST;
      end else if (wrap && !mclk_r) begin
         sel_r <= sel_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mclk_r <= 1'b0;
      end else if (sel_r == CLK_OFF) begin
         mclk_r <= 1'b0;
      end else if (wrap) begin
         mclk_r <= ~mclk_r;
      end
   end

   assign mclk_o = mclk_r;

endmodule : mcuf_clkdiv

// ---- mcuf_ctrl.sv ----
// Upper fields of the modem control register (bits 12 to 47) and the logic they steer:
// receive detection and conditioning, output clock, extended feature gating, header values.
// Assumes the serial host front end delivers each completed write session as one strobe
// with the data and the session length, synchronous to clk_i.
`timescale 1ns/1ns

// Notes on behaviour
// - SPI code 00: carrier flag, outputs always run.
// - Code 01: outputs held low without carrier.
// - Codes 1x preamble; 11 gates on preamble, lock.
// - Mode pin chooses SPI or UART meaning.
// - Frame counting needs header recognition and extension.
// - Bit 21 extends register, enables bits 17-19.
// - Frame header sixteen bits, reset 9B58h.
// - Frame length words, 01h to FFh, reset 08h.
// - Upper 24 bits writable only when extended.
// - UART codes: 10 free carrier, 11 conditioned.
module mcuf_ctrl
   import mcuf_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Register write session and readback
   input  wire logic              wr_valid_i,
   input  wire logic              wr_long_i,
   input  wire logic [CTRL_W-1:0] wr_data_i,
   output logic      [CTRL_W-1:0] rd_data_o,
   // Host mode pin, high for UART
   input  wire logic              uart_mode_i,
   // Receive path
   input  wire mcuf_rx_t          rx_i,
   output logic                   detect_indicator_o,
   output logic                   rx_bit_clock_o,
   output logic                   rx_data_o,
   output logic                   det_cfg_illegal_o,
   // Decoded configuration and clock output
   output mcuf_cfg_t              cfg_o,
   output logic                   frame_len_valid_o,
   output logic                   mclk_o
);

   logic [1:0]  det_r;
   logic        mains_r;
   logic [1:0]  clk_sel_r;
   logic        freeze_r;
   logic        hdr_rec_r;
   logic        fl_cnt_r;
   logic        hdr_len_r;
   logic        ext_r;
   logic        sens_r;
   logic        filt_r;
   logic [15:0] hdr_r;
   logic [7:0]  len_r;
   logic        detect_nxt;
   logic        gate_nxt;
   logic        idle_lvl;
   logic        det_r_ok;
   logic        illegal_nxt;
   logic        ind_r;
   logic        rclk_r;
   logic        rdat_r;
   logic        illegal_r;
   mcuf_cfg_t   cfg_r;
   logic        len_ok_r;

   // Low half of the register (bits 12 to 23) is written by every session.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         det_r     <= DET_RST;
         mains_r   <= MAINS_RST;
         clk_sel_r <= CLK_RST;
         freeze_r  <= FREEZE_RST;
         hdr_rec_r <= HDRREC_RST;
         fl_cnt_r  <= FLCNT_RST;
         hdr_len_r <= HDRLEN_RST;
         ext_r     <= EXT_RST;
         sens_r    <= SENS_RST;
         filt_r    <= FILT_RST;
      end else if (wr_valid_i) begin
         det_r     <= wr_data_i[DET_HI:DET_LO];
         mains_r   <= wr_data_i[MAINS_BIT];
         clk_sel_r <= wr_data_i[CLK_HI:CLK_LO];
         freeze_r  <= wr_data_i[FREEZE_BIT];
         hdr_rec_r <= wr_data_i[HDRREC_BIT];
         fl_cnt_r  <= wr_data_i[FLCNT_BIT];
         hdr_len_r <= wr_data_i[HDRLEN_BIT];
         ext_r     <= wr_data_i[EXT_BIT];
         sens_r    <= wr_data_i[SENS_BIT];
         filt_r    <= wr_data_i[FILT_BIT];
      end
   end

   // The upper half is taken only from a 48-bit session that itself sets the extension bit,
   // so a short session can never leave stale upper data half-written.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hdr_r <= HDR_RST;
         len_r <= LEN_RST;
      end else if (wr_valid_i && wr_long_i && wr_data_i[EXT_BIT]) begin
         hdr_r <= wr_data_i[HDR_HI:HDR_LO];
         len_r <= wr_data_i[LEN_HI:LEN_LO];
      end
   end

   // Readback shows the stored fields; bits 0 to 11 belong elsewhere and read as zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= {len_r, hdr_r, filt_r, sens_r, ext_r, hdr_len_r, fl_cnt_r,
                       hdr_rec_r, freeze_r, clk_sel_r, mains_r, det_r, 12'h000};
      end
   end

   // Detection and conditioning, interpreted through the host mode pin.
   always_comb begin
      idle_lvl    = uart_mode_i ? UART_IDLE : 1'b0;
      det_r_ok    = 1'b1;
      detect_nxt  = rx_i.carrier;
      gate_nxt    = 1'b0;
      illegal_nxt = 1'b0;
      if (!uart_mode_i) begin
         unique case (det_r)
            DET_CARR_FREE: begin
               detect_nxt = rx_i.carrier;
            end
            DET_CARR_COND: begin
               detect_nxt = rx_i.carrier;
               gate_nxt   = !rx_i.carrier;
            end
            DET_PRE_FREE: begin
               detect_nxt = rx_i.preamble;
            end
            DET_PRE_COND: begin
               detect_nxt = rx_i.preamble;
               gate_nxt   = !rx_i.preamble || !rx_i.pll_locked;
            end
         endcase
      end else begin
         // Codes 00 and 01 are forbidden here; they fall back to the free carrier setting
         // and raise a flag rather than produce unpredictable receive outputs.
         unique case (det_r)
            DET_CARR_FREE, DET_CARR_COND: begin
               det_r_ok    = 1'b0;
               detect_nxt  = rx_i.carrier;
            end
            DET_PRE_FREE: begin
               detect_nxt = rx_i.carrier;
            end
            DET_PRE_COND: begin
               gate_nxt = !rx_i.carrier;
            end
         endcase
         illegal_nxt = !det_r_ok;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ind_r     <= 1'b0;
         rclk_r    <= 1'b0;
         rdat_r    <= 1'b0;
         illegal_r <= 1'b0;
      end else begin
         ind_r     <= detect_nxt;
         rclk_r    <= gate_nxt ? 1'b0 : rx_i.bit_clock;
         rdat_r    <= gate_nxt ? idle_lvl : rx_i.data;
         illegal_r <= illegal_nxt;
      end
   end

   // Freeze, header recognition and frame counting act only while the extension bit is set.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_r    <= '0;
         len_ok_r <= 1'b0;
      end else begin
         cfg_r.freeze_en    <= ext_r && !freeze_r;
         cfg_r.hdr_rec_en   <= ext_r && hdr_rec_r;
         cfg_r.frame_cnt_en <= ext_r && hdr_rec_r && fl_cnt_r;
         cfg_r.hdr_16bit    <= hdr_len_r;
         cfg_r.mains_async  <= mains_r;
         cfg_r.high_sens    <= sens_r;
         cfg_r.in_filter    <= filt_r;
         cfg_r.frame_header <= hdr_r;
         cfg_r.frame_len    <= len_r;
         len_ok_r           <= (len_r != LEN_ZERO);
      end
   end

   mcuf_clkdiv u_clkdiv (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .sel_i  (clk_sel_r),
      .mclk_o (mclk_o)
   );

   assign detect_indicator_o = ind_r;
   assign rx_bit_clock_o     = rclk_r;
   assign rx_data_o          = rdat_r;
   assign det_cfg_illegal_o  = illegal_r;
   assign cfg_o              = cfg_r;
   assign frame_len_valid_o  = len_ok_r;

endmodule : mcuf_ctrl

// ---- mcuf_monitor.sv ----
// Checker for the modem control upper fields, bound to mcuf_ctrl.
// Assumes one clock domain and the registered output timing of the block.
`timescale 1ns/1ns
module mcuf_monitor
   import mcuf_pkg::*;
(
   // Clock and reset
   input wire logic              clk_i,
   input wire logic              rst_i,
   // Watched ports
   input wire logic              wr_valid_i,
   input wire logic              wr_long_i,
   input wire logic [CTRL_W-1:0] wr_data_i,
   input wire logic [CTRL_W-1:0] rd_data_o,
   input wire logic              uart_mode_i,
   input wire mcuf_rx_t          rx_i,
   input wire logic              detect_indicator_o,
   input wire logic              rx_bit_clock_o,
   input wire logic              rx_data_o,
   input wire logic              det_cfg_illegal_o,
   input wire mcuf_cfg_t         cfg_o,
   input wire logic              frame_len_valid_o,
   input wire logic              mclk_o
);
   logic       live_r;
   logic [3:0] off_r;
   logic [1:0] code;
   // The readback code is the one that steered the receive outputs of this cycle.
   assign code = rd_data_o[DET_HI:DET_LO];
   always_ff @(posedge clk_i) begin
      live_r <= !rst_i;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || rd_data_o[CLK_HI:CLK_LO] != CLK_OFF) off_r <= 4'h0;
      else if (off_r != 4'hf) off_r <= off_r + 4'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_long_wr;
      wr_valid_i && wr_long_i && wr_data_i[EXT_BIT];
   endsequence
   sequence s_short_wr;
      wr_valid_i && !(wr_long_i && wr_data_i[EXT_BIT]) ##1 !wr_valid_i;
   endsequence
   a_low_lands: assert property (wr_valid_i |-> ##2
      rd_data_o[23:0] == {$past(wr_data_i[23:12], 2), 12'h000}) else $error("low bits lost");
   a_long_lands: assert property (s_long_wr |-> ##2
      rd_data_o[47:24] == $past(wr_data_i[47:24], 2)) else $error("upper bits lost");
   a_upper_kept: assert property (s_short_wr |=> $stable(rd_data_o[47:24]))
      else $error("upper bits changed");
   a_fields_decode: assert property (live_r |-> cfg_o.frame_header == rd_data_o[39:24]
      && cfg_o.frame_len == rd_data_o[47:40] && cfg_o.hdr_16bit == rd_data_o[20]
      && cfg_o.mains_async == rd_data_o[MAINS_BIT] && cfg_o.high_sens == rd_data_o[SENS_BIT]
      && cfg_o.in_filter == rd_data_o[FILT_BIT])
      else $error("field decode wrong");
   a_ext_gate: assert property (live_r |-> cfg_o.hdr_rec_en == (rd_data_o[21] && rd_data_o[18])
      && cfg_o.frame_cnt_en == (rd_data_o[21] && rd_data_o[18] && rd_data_o[19])
      && cfg_o.freeze_en == (rd_data_o[EXT_BIT] && !rd_data_o[FREEZE_BIT]))
      else $error("extension gate wrong");
   a_len_valid: assert property (live_r |-> frame_len_valid_o == (rd_data_o[47:40] != LEN_ZERO))
      else $error("length flag wrong");
   a_det_source: assert property (live_r |-> detect_indicator_o ==
      (($past(uart_mode_i) || !code[1]) ? $past(rx_i.carrier) : $past(rx_i.preamble)))
      else $error("indicator source wrong");
   a_free_pass: assert property (live_r && !code[0] |->
      rx_bit_clock_o == $past(rx_i.bit_clock) && rx_data_o == $past(rx_i.data))
      else $error("free path gated");
   a_spi_gate: assert property (live_r && !$past(uart_mode_i) && ((code == DET_CARR_COND
      && !$past(rx_i.carrier)) || (code == DET_PRE_COND && !($past(rx_i.preamble)
      && $past(rx_i.pll_locked)))) |-> !rx_bit_clock_o && !rx_data_o) else $error("spi gate off");
   a_uart_idle: assert property (live_r && $past(uart_mode_i) && code == DET_PRE_COND
      && !$past(rx_i.carrier) |-> !rx_bit_clock_o && rx_data_o == UART_IDLE)
      else $error("uart gate off");
   a_code_flag: assert property (live_r |-> det_cfg_illegal_o == ($past(uart_mode_i) && !code[1]))
      else $error("illegal flag wrong");
   a_clk_off: assert property (off_r == 4'hf |-> !mclk_o) else $error("clock not off");
endmodule : mcuf_monitor
bind mcuf_ctrl mcuf_monitor mcuf_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wr_valid_i(wr_valid_i), .wr_long_i(wr_long_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
   .uart_mode_i(uart_mode_i), .rx_i(rx_i), .detect_indicator_o(detect_indicator_o),
   .rx_bit_clock_o(rx_bit_clock_o), .rx_data_o(rx_data_o), .det_cfg_illegal_o(det_cfg_illegal_o),
   .cfg_o(cfg_o), .frame_len_valid_o(frame_len_valid_o), .mclk_o(mclk_o));

// ---- mcuf_host_model.sv ----
// Host model: delivers control register write sessions to the block.
// Assumes a session is taken on the rising edge where the strobe is high.
`timescale 1ns/1ns
module mcuf_host_model
   import mcuf_pkg::*;
(
   // Clock
   input  wire logic         clk_i,
   // Write session
   output logic              wr_valid_o,
   output logic              wr_long_o,
   output logic [CTRL_W-1:0] wr_data_o
);
   initial begin
      wr_valid_o = 1'b0;
      wr_long_o  = 1'b0;
      wr_data_o  = '0;
   end
   // Idle lines carry the inverse so a stale image can never look valid.
   task automatic write(input logic lng, input logic [CTRL_W-1:0] d);
      @(posedge clk_i) #5;
      wr_valid_o = 1'b1;
      wr_long_o  = lng;
      wr_data_o  = d;
      @(posedge clk_i) #5;
      wr_valid_o = 1'b0;
      wr_long_o  = ~lng;
      wr_data_o  = ~d;
   endtask : write
endmodule : mcuf_host_model

// ---- tb.sv ----
// Testbench for the modem control upper fields.
// Assumes the host model for write sessions; the bench drives mode pin and receive path.
`timescale 1ns/1ns
module tb;
   import mcuf_pkg::*;
   logic        clk_i, rst_i, wr_valid, wr_long, uart_mode;
   logic        det_ind, rx_clk, rx_dat, illegal, len_ok, mclk;
   logic [47:0] wr_data, rd_data;
   mcuf_rx_t    rx;
   mcuf_cfg_t   cfg;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   mcuf_host_model mcuf_host_model_inst (.clk_i(clk_i), .wr_valid_o(wr_valid),
      .wr_long_o(wr_long), .wr_data_o(wr_data));
   mcuf_ctrl mcuf_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wr_valid_i(wr_valid),
      .wr_long_i(wr_long), .wr_data_i(wr_data), .rd_data_o(rd_data), .uart_mode_i(uart_mode),
      .rx_i(rx), .detect_indicator_o(det_ind), .rx_bit_clock_o(rx_clk), .rx_data_o(rx_dat),
      .det_cfg_illegal_o(illegal), .cfg_o(cfg), .frame_len_valid_o(len_ok), .mclk_o(mclk));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #5;
   endtask : tick
   task automatic wr_low(input logic [11:0] f);
      mcuf_host_model_inst.write(1'b0, {24'h00_0000, f, 12'h000});
      tick(1);
   endtask : wr_low
   task automatic t_reset;
      chk("reset image", rd_data, 48'h089b_5813_6000);
      chk("reset decode", 48'({cfg.hdr_16bit, cfg.hdr_rec_en, cfg.frame_cnt_en,
         cfg.high_sens, cfg.in_filter, len_ok}), 48'h21);
      chk("reset freeze mains", 48'({cfg.freeze_en, cfg.mains_async}), 48'h1);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_upper;
      mcuf_host_model_inst.write(1'b1, 48'h1122_2203_6000);
      tick(1);
      chk("long without ext", rd_data, 48'h089b_5803_6000);
      chk("hdr 8bit", 48'(cfg.hdr_16bit), 48'h0);
      mcuf_host_model_inst.write(1'b0, 48'h1122_2233_6000);
      tick(1);
      chk("short with ext", rd_data, 48'h089b_5833_6000);
      mcuf_host_model_inst.write(1'b1, 48'hff00_003d_6000);
      tick(1);
      chk("long with ext", rd_data, 48'hff00_003d_6000);
      chk("ext enables", 48'({cfg.frame_cnt_en, cfg.hdr_rec_en, len_ok}), 48'h7);
      mcuf_host_model_inst.write(1'b1, 48'h00ff_fff9_6000);
      tick(1);
      chk("count no recog", 48'({cfg.frame_cnt_en, len_ok}), 48'h0);
      chk("feature bits", 48'({cfg.freeze_en, cfg.high_sens, cfg.in_filter,
         cfg.mains_async}), 48'hf);
      chk("header ffff", 48'(cfg.frame_header), 48'h0000_0000_ffff);
      $display("t_upper done");
   endtask : t_upper
   task automatic t_detect;
      logic g;
      logic [1:0] c;
      for (int m = 0; m < 2; m++) begin
         for (int ci = 0; ci < 4; ci++) begin
            c = 2'(ci);
            uart_mode = m[0];
            wr_low({10'h04d, c});
            for (int k = 0; k < 8; k++) begin
               rx = '{carrier: k[0], preamble: k[1], pll_locked: k[2], bit_clock: 1'b1,
                      data: !m[0]};
               g = m[0] ? (c == DET_PRE_COND && !k[0]) : ((c == DET_CARR_COND && !k[0])
                   || (c == DET_PRE_COND && !(k[1] && k[2])));
               tick(1);
               chk("indicator", 48'(det_ind), 48'((m[0] || !c[1]) ? k[0] : k[1]));
               chk("rx clock", 48'(rx_clk), 48'(!g));
               chk("rx data", 48'(rx_dat), 48'(g ? m[0] : !m[0]));
               chk("illegal code", 48'(illegal), 48'(m[0] && !c[1]));
            end
         end
      end
      uart_mode = 1'b0;
      $display("t_detect done");
   endtask : t_detect
   task automatic t_clock;
      int per, t0;
      logic prev;
      for (int ci = 0; ci < 3; ci++) begin
         wr_low(12'h126 | 12'(ci << 3));
         tick(20);
         per = 0;
         t0 = -1;
         prev = mclk;
         for (int n = 0; n < 40; n++) begin
            tick(1);
            if (mclk === 1'b1 && prev === 1'b0) begin
               if (t0 >= 0 && per == 0) per = n - t0;
               t0 = n;
            end
            prev = mclk;
         end
         chk("mclk period", 48'(per), 48'(2 << ci));
      end
      wr_low(12'h13e);
      tick(12);
      for (int n = 0; n < 16; n++) begin
         tick(1);
         chk("mclk off", 48'(mclk), 48'h0);
      end
      $display("t_clock done");
   endtask : t_clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // The ceiling is several times the length of the whole sequence.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   initial begin
      rst_i = 1'b1;
      uart_mode = 1'b0;
      rx = '0;
      tick(16);
      rst_i = 1'b0;
      tick(2);
      t_reset;
      t_upper;
      t_detect;
      t_clock;
      tally_and_finish;
   end
endmodule : tb
